// ### i2c_port_cfg.svh
// constants for the two-wire register slave port
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// upper six bits of the 7-bit slave address
`define SLV_ADDR_HI 6'h34
// register file geometry
`define REG_AW 7
`define REG_DW 8
// sub-address field positions
`define SUB_AUTOINC_BIT 7
// direction bit value meaning master reads
`define DIR_READ 1'h1
// cycles from memory address to shift register load
`define RD_LOAD_CYC 3'h2
// clock period and least low time of a fast-mode bus clock
`define CLK_PERIOD_NS 25
`define FAST_LOW_NS 1300
`define FAST_LOW_CYC ((`FAST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// cycles from pin to synchronised edge, worst case
`define SYNC_LAT_CYC 3

`endif

// ### i2c_port_pkg.sv
// types for the two-wire register slave port
package i2c_port_pkg;

  typedef enum logic [3:0] {
    PS_IDLE,
    PS_RX_ADDR,
    PS_ACK_ADDR,
    PS_RX_SUB,
    PS_ACK_SUB,
    PS_RX_DATA,
    PS_ACK_DATA,
    PS_TX_LOAD,
    PS_TX_DATA,
    PS_TX_ACK,
    PS_WAIT_STOP
  } port_state_t;

endpackage

// ### reg_bank.sv
// register storage with a bus-side port and a user-side port
`timescale 1ns/10ps
module reg_bank #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic ref_clk_i,
  input wire logic a_wr_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [DW-1:0] a_wdata_i,
  output logic [DW-1:0] a_rdata_o,
  input wire logic b_wr_i,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [DW-1:0] b_wdata_i,
  output logic [DW-1:0] b_rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  if (AW < 1 || DW < 1) begin : g_chk
    $error("reg_bank: widths must be positive");
  end

  // bus-side write wins when both ports hit one word
  always_ff @(posedge ref_clk_i) begin
    if (a_wr_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_wr_i && !(a_wr_i && a_addr_i == b_addr_i)) begin
      mem[b_addr_i] <= b_wdata_i;
    end
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end

endmodule

// ### i2c_register_slave_port.sv
// two-wire slave port giving a bus master access to the register bank
// Notes on behaviour
// - chip-select high picks two-wire slave; low enables four-wire serial port
// - non two-wire port selectable between three-wire and four-wire modes
// - clock, data and address-select pins shared between both serial ports
// - works at standard and fast bus clock rates
// - start is data falling while clock high; bus busy until stop
// - first byte is 7-bit address plus direction; match means addressed
// - receiver pulls data low through acknowledge clock; transmitter releases it
// - addressed receiver acknowledges address, sub-address and every data byte
// - sub-address: low seven bits register, top bit asks auto-increment
// - with auto-increment set, register address steps after each data byte
// - address-plus-direction byte takes one of four values
// - write: start, address, ack, sub-address, ack, data with acks, stop
// - idle bus: neither clock nor data driven low
// - read: slave sends bytes; master acks more, withholds on last
// - bytes are eight bits, msb first, count per transfer unlimited
// - stop is data rising while clock high; ends transfer
// - slave holds clock low while loading a read byte; master waits for release
`timescale 1ns/10ps
`include "i2c_port_cfg.svh"
module i2c_register_slave_port #(
  parameter int AW = `REG_AW,
  parameter int DW = `REG_DW
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_pin_i,
  input wire logic port_clock_pin_i,
  output logic port_clock_pin_o,
  output logic port_clock_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  input wire logic addr_select_out_pin_i,
  input wire logic spi_three_wire_i,
  output logic spi_enable_o,
  output logic spi_three_wire_o,
  output logic bus_busy_o,
  output logic addressed_o,
  output logic reg_wr_o,
  output logic [AW-1:0] reg_addr_o,
  output logic [DW-1:0] reg_wdata_o,
  input wire logic user_wr_i,
  input wire logic [AW-1:0] user_addr_i,
  input wire logic [DW-1:0] user_wdata_i,
  output logic [DW-1:0] user_rdata_o
);

  if (AW != 7 || DW != 8) begin : g_width_chk
    $error("sub-address carries 7 address bits and 8-bit data only");
  end
  // read load fits inside fast-mode low time
  if (`RD_LOAD_CYC + `SYNC_LAT_CYC + 2 >= `FAST_LOW_CYC) begin : g_rate_chk
    $error("read load too slow for fast-mode clock low time");
  end

  // two-stage synchronisers, third stage for edges
  logic scl_m_r, scl_s_r, scl_p_r;
  logic sda_m_r, sda_s_r, sda_p_r;
  logic cs_m_r, cs_s_r;
  logic asel_m_r, asel_s_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_m_r <= 1'h1;
      scl_s_r <= 1'h1;
      scl_p_r <= 1'h1;
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
      sda_p_r <= 1'h1;
      cs_m_r <= 1'h1;
      cs_s_r <= 1'h1;
      asel_m_r <= 1'h0;
      asel_s_r <= 1'h0;
    end else begin
      scl_m_r <= port_clock_pin_i;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= serial_in_pin_i;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
      cs_m_r <= cs_pin_i;
      cs_s_r <= cs_m_r;
      asel_m_r <= addr_select_out_pin_i;
      asel_s_r <= asel_m_r;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, i2c_mode;
  assign scl_rise = scl_s_r & ~scl_p_r;
  assign scl_fall = ~scl_s_r & scl_p_r;
  // start: data falls with clock high
  assign start_det = scl_s_r & scl_p_r & ~sda_s_r & sda_p_r;
  // stop: data rises with clock high
  assign stop_det = scl_s_r & scl_p_r & sda_s_r & ~sda_p_r;
  assign i2c_mode = cs_s_r;

  i2c_port_pkg::port_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [DW-1:0] shreg_r, shreg_nxt;
  logic byte_done_r, byte_done_nxt;
  logic sda_drive_r, sda_drive_nxt;
  logic scl_hold_r, scl_hold_nxt;
  logic [AW-1:0] sub_addr_r, sub_addr_nxt;
  logic auto_inc_r, auto_inc_nxt;
  logic dir_rd_r, dir_rd_nxt;
  logic busy_r, busy_nxt;
  logic addressed_r, addressed_nxt;
  logic [2:0] load_cnt_r, load_cnt_nxt;
  logic mem_wr_r, mem_wr_nxt;
  logic [AW-1:0] wr_addr_r, wr_addr_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic spi_en_r, spi_en_nxt;
  logic three_wire_r, three_wire_nxt;
  logic [DW-1:0] mem_rdata;
  logic [AW-1:0] mem_addr;
  logic [AW-1:0] sub_step;
  logic [AW-1:0] own_addr;

  // seven-bit sum wraps to zero past the top
  assign sub_step = sub_addr_r + {{(AW-1){1'b0}}, auto_inc_r};
  // select pin supplies the low address bit
  assign own_addr = {`SLV_ADDR_HI, asel_s_r};
  assign mem_addr = mem_wr_r ? wr_addr_r : sub_addr_r;

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shreg_nxt = shreg_r;
    byte_done_nxt = byte_done_r;
    sda_drive_nxt = sda_drive_r;
    scl_hold_nxt = scl_hold_r;
    sub_addr_nxt = sub_addr_r;
    auto_inc_nxt = auto_inc_r;
    dir_rd_nxt = dir_rd_r;
    busy_nxt = busy_r;
    addressed_nxt = addressed_r;
    load_cnt_nxt = load_cnt_r;
    mem_wr_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wdata_nxt = wdata_r;
    // three-wire choice only meaningful with the serial port enabled
    spi_en_nxt = ~i2c_mode;
    three_wire_nxt = ~i2c_mode & spi_three_wire_i;
    if (!i2c_mode) begin
      // shared pins released to the other port
      state_nxt = i2c_port_pkg::PS_IDLE;
      sda_drive_nxt = 1'b0;
      scl_hold_nxt = 1'b0;
      busy_nxt = 1'b0;
      addressed_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = i2c_port_pkg::PS_IDLE;
      sda_drive_nxt = 1'b0;
      scl_hold_nxt = 1'b0;
      busy_nxt = 1'b0;
      addressed_nxt = 1'b0;
    end else if (start_det) begin
      // start or repeated start marks bus busy
      state_nxt = i2c_port_pkg::PS_RX_ADDR;
      busy_nxt = 1'b1;
      addressed_nxt = 1'b0;
      bit_cnt_nxt = 3'h0;
      byte_done_nxt = 1'b0;
      sda_drive_nxt = 1'b0;
      scl_hold_nxt = 1'b0;
    end else begin
      unique case (state_r)
        i2c_port_pkg::PS_IDLE, i2c_port_pkg::PS_WAIT_STOP: begin
          // nothing driven outside our own transfer
          sda_drive_nxt = 1'b0;
          scl_hold_nxt = 1'b0;
        end
        i2c_port_pkg::PS_RX_ADDR, i2c_port_pkg::PS_RX_SUB,
        i2c_port_pkg::PS_RX_DATA: begin
          if (scl_rise) begin
            // msb first, eight bits per byte
            shreg_nxt = {shreg_r[DW-2:0], sda_s_r};
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            byte_done_nxt = (bit_cnt_r == 3'h7);
          end else if (scl_fall && byte_done_r) begin
            byte_done_nxt = 1'b0;
            if (state_r == i2c_port_pkg::PS_RX_ADDR) begin
              if (shreg_r[DW-1:1] == own_addr) begin
                addressed_nxt = 1'b1;
                dir_rd_nxt = (shreg_r[0] == `DIR_READ);
                sda_drive_nxt = 1'b1;
                state_nxt = i2c_port_pkg::PS_ACK_ADDR;
              end else begin
                state_nxt = i2c_port_pkg::PS_WAIT_STOP;
              end
            end else if (state_r == i2c_port_pkg::PS_RX_SUB) begin
              sub_addr_nxt = shreg_r[AW-1:0];
              auto_inc_nxt = shreg_r[`SUB_AUTOINC_BIT];
              sda_drive_nxt = 1'b1;
              state_nxt = i2c_port_pkg::PS_ACK_SUB;
            end else begin
              // store data byte and acknowledge it
              mem_wr_nxt = 1'b1;
              wr_addr_nxt = sub_addr_r;
              wdata_nxt = shreg_r;
              // step address after each written byte when auto-increment is set
              sub_addr_nxt = sub_step;
              sda_drive_nxt = 1'b1;
              state_nxt = i2c_port_pkg::PS_ACK_DATA;
            end
          end
        end
        i2c_port_pkg::PS_ACK_ADDR, i2c_port_pkg::PS_ACK_SUB,
        i2c_port_pkg::PS_ACK_DATA: begin
          // hold data low through ack clock high, release on its fall
          if (scl_fall) begin
            sda_drive_nxt = 1'b0;
            bit_cnt_nxt = 3'h0;
            if (state_r == i2c_port_pkg::PS_ACK_ADDR && dir_rd_r) begin
              // read address after repeated start goes to transmit
              state_nxt = i2c_port_pkg::PS_TX_LOAD;
              load_cnt_nxt = 3'h0;
              scl_hold_nxt = 1'b1;
            end else if (state_r == i2c_port_pkg::PS_ACK_ADDR) begin
              state_nxt = i2c_port_pkg::PS_RX_SUB;
            end else begin
              state_nxt = i2c_port_pkg::PS_RX_DATA;
            end
          end
        end
        i2c_port_pkg::PS_TX_LOAD: begin
          // clock held low until the byte is ready
          scl_hold_nxt = 1'b1;
          load_cnt_nxt = load_cnt_r + 3'h1;
          if (load_cnt_r == `RD_LOAD_CYC) begin
            shreg_nxt = mem_rdata;
            sda_drive_nxt = ~mem_rdata[DW-1];
            // step address after each read byte when auto-increment is set
            sub_addr_nxt = sub_step;
            scl_hold_nxt = 1'b0;
            bit_cnt_nxt = 3'h0;
            byte_done_nxt = 1'b0;
            state_nxt = i2c_port_pkg::PS_TX_DATA;
          end
        end
        i2c_port_pkg::PS_TX_DATA: begin
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            byte_done_nxt = (bit_cnt_r == 3'h7);
          end else if (scl_fall) begin
            if (byte_done_r) begin
              // transmitter releases data for the master ack
              byte_done_nxt = 1'b0;
              sda_drive_nxt = 1'b0;
              state_nxt = i2c_port_pkg::PS_TX_ACK;
            end else begin
              shreg_nxt = {shreg_r[DW-2:0], 1'b0};
              sda_drive_nxt = ~shreg_r[DW-2];
            end
          end
        end
        i2c_port_pkg::PS_TX_ACK: begin
          if (scl_rise) begin
            if (sda_s_r) begin
              state_nxt = i2c_port_pkg::PS_WAIT_STOP;
            end else begin
              byte_done_nxt = 1'b1;
            end
          end else if (scl_fall && byte_done_r) begin
            // master acknowledge asks for another byte
            byte_done_nxt = 1'b0;
            load_cnt_nxt = 3'h0;
            scl_hold_nxt = 1'b1;
            state_nxt = i2c_port_pkg::PS_TX_LOAD;
          end
        end
        default: begin
          state_nxt = i2c_port_pkg::PS_IDLE;
          sda_drive_nxt = 1'b0;
          scl_hold_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= i2c_port_pkg::PS_IDLE;
      bit_cnt_r <= 3'h0;
      shreg_r <= 8'h00;
      byte_done_r <= 1'b0;
      sda_drive_r <= 1'b0;
      scl_hold_r <= 1'b0;
      sub_addr_r <= 7'h00;
      auto_inc_r <= 1'b0;
      dir_rd_r <= 1'b0;
      busy_r <= 1'b0;
      addressed_r <= 1'b0;
      load_cnt_r <= 3'h0;
      mem_wr_r <= 1'b0;
      wr_addr_r <= 7'h00;
      wdata_r <= 8'h00;
      spi_en_r <= 1'b0;
      three_wire_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shreg_r <= shreg_nxt;
      byte_done_r <= byte_done_nxt;
      sda_drive_r <= sda_drive_nxt;
      scl_hold_r <= scl_hold_nxt;
      sub_addr_r <= sub_addr_nxt;
      auto_inc_r <= auto_inc_nxt;
      dir_rd_r <= dir_rd_nxt;
      busy_r <= busy_nxt;
      addressed_r <= addressed_nxt;
      load_cnt_r <= load_cnt_nxt;
      mem_wr_r <= mem_wr_nxt;
      wr_addr_r <= wr_addr_nxt;
      wdata_r <= wdata_nxt;
      spi_en_r <= spi_en_nxt;
      three_wire_r <= three_wire_nxt;
    end
  end

  reg_bank #(
    .AW(AW),
    .DW(DW)
  ) u_bank (
    .ref_clk_i(ref_clk_i),
    .a_wr_i(mem_wr_r),
    .a_addr_i(mem_addr),
    .a_wdata_i(wdata_r),
    .a_rdata_o(mem_rdata),
    .b_wr_i(user_wr_i),
    .b_addr_i(user_addr_i),
    .b_wdata_i(user_wdata_i),
    .b_rdata_o(user_rdata_o)
  );

  // open-drain pins only ever pull low
  assign serial_in_pin_o = 1'b0;
  assign port_clock_pin_o = 1'b0;
  assign serial_in_pin_oe_o = sda_drive_r;
  assign port_clock_pin_oe_o = scl_hold_r;
  assign spi_enable_o = spi_en_r;
  assign spi_three_wire_o = three_wire_r;
  assign bus_busy_o = busy_r;
  assign addressed_o = addressed_r;
  assign reg_wr_o = mem_wr_r;
  assign reg_addr_o = wr_addr_r;
  assign reg_wdata_o = wdata_r;

endmodule

// ### i2c_register_slave_port_sva.sv
// assertion checker for the two-wire register slave port
`timescale 1ns/10ps
module i2c_register_slave_port_sva #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_pin_i,
  input wire logic port_clock_pin_i,
  input wire logic port_clock_pin_oe_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_in_pin_oe_o,
  input wire logic spi_three_wire_i,
  input wire logic spi_enable_o,
  input wire logic spi_three_wire_o,
  input wire logic bus_busy_o,
  input wire logic addressed_o,
  input wire logic reg_wr_o,
  input wire logic [AW-1:0] reg_addr_o,
  input wire logic [DW-1:0] reg_wdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_spi_on: assert property (!cs_pin_i [*5] |-> spi_enable_o)
    else $error("spi enable missing with chip-select low");
  a_spi_off: assert property (cs_pin_i [*5] |-> !spi_enable_o)
    else $error("spi enable set with chip-select high");
  a_spi_mode: assert property (spi_three_wire_o == (spi_enable_o & $past(spi_three_wire_i)))
    else $error("three-wire mode output wrong");
  a_start_busy: assert property ($fell(serial_in_pin_i) && port_clock_pin_i && cs_pin_i
    |-> ##[1:4] bus_busy_o)
    else $error("start did not make bus busy");
  a_stop_idle: assert property ($rose(serial_in_pin_i) && port_clock_pin_i
    |-> ##[1:4] !bus_busy_o)
    else $error("stop did not free the bus");
  a_idle_quiet: assert property (!bus_busy_o |-> !serial_in_pin_oe_o && !port_clock_pin_oe_o)
    else $error("pins driven while bus idle");
  a_ack_stable: assert property (port_clock_pin_i [*3] |-> $stable(serial_in_pin_oe_o))
    else $error("data drive changed during clock high");
  a_stretch_short: assert property (port_clock_pin_oe_o [*8] |=> !port_clock_pin_oe_o)
    else $error("clock held low too long");
  a_wr_addressed: assert property (reg_wr_o |-> addressed_o && bus_busy_o)
    else $error("register write without address match");
  a_wr_single: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  a_wr_holds: assert property ($changed(reg_addr_o) || $changed(reg_wdata_o) |-> reg_wr_o)
    else $error("write outputs changed without strobe");
  c_write: cover property (reg_wr_o);
  c_stretch: cover property ($rose(port_clock_pin_oe_o));
  c_three: cover property (spi_three_wire_o);
endmodule
bind i2c_register_slave_port i2c_register_slave_port_sva #(.AW(AW), .DW(DW)) u_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_pin_i(cs_pin_i),
  .port_clock_pin_i(port_clock_pin_i), .port_clock_pin_oe_o(port_clock_pin_oe_o),
  .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_oe_o(serial_in_pin_oe_o),
  .spi_three_wire_i(spi_three_wire_i), .spi_enable_o(spi_enable_o),
  .spi_three_wire_o(spi_three_wire_o), .bus_busy_o(bus_busy_o), .addressed_o(addressed_o),
  .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o));

// ### i2c_master_model.sv
// behavioural two-wire bus master facing the slave port
`timescale 1ns/10ps
module i2c_master_model (
  input wire logic ref_clk_i,
  input wire logic dev_clk_oe_i,
  input wire logic dev_data_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic clk_low = 1'b0;
  logic data_low = 1'b0;
  // released lines float high on pull-ups
  assign scl_o = ~(clk_low | dev_clk_oe_i);
  assign sda_o = ~(data_low | dev_data_oe_i);
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask
  // wait while the device stretches the clock
  task automatic rise();
    clk_low = 1'b0;
    for (int i = 0; i < 40 && scl_o !== 1'b1; i++)
      tk(1);
  endtask
  task automatic start();
    tk(1);
    data_low = 1'b0;
    tk(3);
    rise();
    tk(2);
    data_low = 1'b1;
    tk(2);
    clk_low = 1'b1;
  endtask
  // one bit, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    data_low = ~b;
    tk(3);
    rise();
    tk(3);
    r = sda_o;
    tk(1);
    clk_low = 1'b1;
  endtask
  // msb first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--)
      bit_io(v[k], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // acknowledge all bytes but the last
  task automatic rbyte(input logic more, output logic [7:0] v);
    logic r;
    for (int k = 7; k >= 0; k--) begin
      bit_io(1'b1, r);
      v[k] = r;
    end
    bit_io(~more, r);
  endtask
  task automatic stop();
    tk(1);
    data_low = 1'b1;
    tk(3);
    rise();
    tk(2);
    data_low = 1'b0;
    tk(4);
  endtask
endmodule

// ### i2c_register_slave_port_tb.sv
// self-checking bench for the two-wire register slave port
`timescale 1ns/10ps
module i2c_register_slave_port_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_pin = 1'b1;
  logic asel = 1'b0;
  logic three_wire = 1'b0;
  logic [6:0] user_addr = 7'h00;
  logic user_wr = 1'b0;
  logic [7:0] user_wdata = 8'h00;
  wire scl, sda, scl_oe, sda_oe, spi_en, spi_tw, busy, addressed, reg_wr;
  wire scl_do, sda_do;
  wire [6:0] reg_addr;
  wire [7:0] reg_wdata, user_rdata;
  logic [14:0] wq[$];
  int failures = 0;
  int comparisons = 0;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  i2c_register_slave_port u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_pin_i(cs_pin), .port_clock_pin_i(scl),
    .port_clock_pin_o(scl_do), .port_clock_pin_oe_o(scl_oe), .serial_in_pin_i(sda),
    .serial_in_pin_o(sda_do), .serial_in_pin_oe_o(sda_oe), .addr_select_out_pin_i(asel),
    .spi_three_wire_i(three_wire), .spi_enable_o(spi_en), .spi_three_wire_o(spi_tw),
    .bus_busy_o(busy), .addressed_o(addressed), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .user_wr_i(user_wr), .user_addr_i(user_addr),
    .user_wdata_i(user_wdata), .user_rdata_o(user_rdata));
  i2c_master_model u_mst (.ref_clk_i(ref_clk_i), .dev_clk_oe_i(scl_oe),
    .dev_data_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  always @(negedge ref_clk_i) if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
  task automatic chk(input string n, input logic [14:0] e, input logic [14:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ea);
    logic k;
    u_mst.wbyte(b, k);
    chk("acknowledge", 15'(ea), 15'(k));
  endtask
  task automatic popchk(input logic [6:0] a, input logic [7:0] d);
    chk("bus write", {a, d}, (wq.size() > 0) ? wq.pop_front() : 15'h7fff);
  endtask
  task automatic urd(input logic [6:0] a, input logic [7:0] d);
    user_addr = a;
    u_mst.tk(2);
    chk("user read", 15'(d), 15'(user_rdata));
  endtask
  task automatic uwr(input logic [6:0] a, input logic [7:0] d);
    user_addr = a;
    user_wdata = d;
    user_wr = 1'b1;
    u_mst.tk(1);
    user_wr = 1'b0;
  endtask
  task automatic wr_xfer(input logic [7:0] ad, sub, d0, d1);
    u_mst.start();
    send(ad, 1'b1);
    send(sub, 1'b1);
    send(d0, 1'b1);
    send(d1, 1'b1);
    u_mst.stop();
    chk("busy after stop", 15'h0000, 15'(busy));
  endtask
  task automatic rd_xfer(input logic [7:0] adw, sub, adr, e0, e1);
    logic [7:0] v;
    u_mst.start();
    send(adw, 1'b1);
    send(sub, 1'b1);
    u_mst.start();
    send(adr, 1'b1);
    u_mst.rbyte(1'b1, v);
    chk("read byte", 15'(e0), 15'(v));
    u_mst.rbyte(1'b0, v);
    chk("read byte", 15'(e1), 15'(v));
    u_mst.stop();
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    u_mst.tk(4);
    rst_i = 1'b0;
    u_mst.tk(4);
    wr_xfer(8'hd0, 8'h85, 8'ha1, 8'hb2);
    popchk(7'h05, 8'ha1);
    popchk(7'h06, 8'hb2);
    urd(7'h06, 8'hb2);
    chk("pin drive level", 15'h0000, 15'({scl_do, sda_do}));
    $display("test 1 done");
    wr_xfer(8'hd0, 8'hff, 8'hc3, 8'hd4);
    popchk(7'h7f, 8'hc3);
    popchk(7'h00, 8'hd4);
    $display("test 2 done");
    rd_xfer(8'hd0, 8'h85, 8'hd1, 8'ha1, 8'hb2);
    uwr(7'h10, 8'h3c);
    rd_xfer(8'hd0, 8'h10, 8'hd1, 8'h3c, 8'h3c);
    $display("test 3 done");
    asel = 1'b1;
    u_mst.start();
    send(8'hd0, 1'b0);
    chk("addressed", 15'h0000, 15'(addressed));
    u_mst.stop();
    wr_xfer(8'hd2, 8'h20, 8'h5a, 8'h66);
    popchk(7'h20, 8'h5a);
    popchk(7'h20, 8'h66);
    rd_xfer(8'hd2, 8'h20, 8'hd3, 8'h66, 8'h66);
    $display("test 4 done");
    cs_pin = 1'b0;
    three_wire = 1'b1;
    u_mst.tk(8);
    chk("spi enable", 15'h0001, 15'(spi_en));
    chk("three wire", 15'h0001, 15'(spi_tw));
    u_mst.start();
    send(8'hd2, 1'b0);
    u_mst.stop();
    three_wire = 1'b0;
    u_mst.tk(4);
    chk("three wire", 15'h0000, 15'(spi_tw));
    cs_pin = 1'b1;
    u_mst.tk(8);
    chk("spi enable", 15'h0000, 15'(spi_en));
    chk("spurious writes", 15'h0000, 15'(wq.size()));
    $display("test 5 done");
    final_report();
  end
endmodule
